// ---- src/tap_chain.sv ----
// two-tap jtag chain with otp store, security load and boot sequencing
`timescale 1ns/100ps
`default_nettype none
module tap_chain
  import tap_pkg::*;
#(
  parameter int SECTORS = OTP_SECTORS,
  parameter int ROWS    = OTP_ROWS
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // jtag pins
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_en,
  // boot control
  input  wire logic              pll_lock,
  output logic                   boot_go,
  output logic [31:0]            sec_reg,
  // otp programming ports
  input  wire logic              prog_wr,
  input  wire otp_prog_type      prog,
  output logic                   prog_busy,
  // sram port for the boot copy and tile accesses
  input  wire logic              mem_en,
  input  wire logic              mem_we,
  input  wire logic [3:0]        mem_be,
  input  wire logic [SRAM_ADDR_W-1:0] mem_addr,
  input  wire logic [31:0]       mem_wdata,
  output logic [31:0]            mem_rdata
);

  localparam int OTP_DEPTH = SECTORS * ROWS;

  // boot sequencing phases
  typedef enum logic [1:0] {
    B_WAIT = 2'h0, B_SEC = 2'h1, B_COPY = 2'h3, B_RUN = 2'h2
  } boot_type;

  typedef struct packed {
    jtag_pins_type          p1;
    jtag_pins_type          p2;
    logic                   tck_old;
    logic [1:0]             lock_sy;
    boot_type               boot;
    logic [31:0]            sec;
    logic [OTP_ADDR_W-1:0]  rd_ptr;
    logic [31:0]            rdata;
    logic [SRAM_ADDR_W-1:0] cp_ptr;
    logic [15:0]            otp_addr;
    logic                   busy;
  } top_type;

  top_type s_q;
  top_type s_d;

  // one-time store and shared sram, both 32 bits wide
  logic [OTP_WORD_W-1:0] otp_mem [OTP_DEPTH];
  logic [31:0]           sram    [2**SRAM_ADDR_W];

  // unprogrammed fuses read as zero, so a blank part boots clean
  initial begin
    for (int i = 0; i < OTP_DEPTH; i++) otp_mem[i] = '0;
  end

  // tap wires
  logic            tck_rise;
  logic            tck_fall;
  logic [IR_W-1:0] bs_ir;
  logic [IR_W-1:0] ch_ir;
  logic [31:0]     bs_dr;
  logic [31:0]     ch_dr;
  logic [31:0]     bs_cap;
  logic [31:0]     ch_cap;
  logic            ch_upd;
  logic            bs_tdo;
  logic            ch_tdo;
  logic            bs_oe;
  logic            ch_oe;
  logic            jtag_off;
  logic            otp_block;
  logic [31:0]     id_word;
  logic [31:0]     user_word;
  logic            otp_wr_ok;

  // lock on a sector bit or the master lock keeps a row unwritten
  function automatic logic row_locked(input logic [31:0] sec,
                                      input logic [15:0] a);
    row_locked = sec[12] || sec[8 + int'(a[10:9])];
  endfunction : row_locked

  // ---------------------------------------------------------------
  // identity words
  // ---------------------------------------------------------------
  assign id_word   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign user_word = {s_q.sec[31:SEC_UID_LSB], 6'h00,
                      SILICON_REV};
  assign jtag_off  = s_q.sec[SEC_JTAG_OFF];
  assign otp_block = s_q.sec[SEC_OTP_BLOCK];

  // test clock edges from the twice-sampled pin
  assign tck_rise = s_q.p2.tck & ~s_q.tck_old;
  assign tck_fall = ~s_q.p2.tck & s_q.tck_old;

  // ---------------------------------------------------------------
  // capture values for each tap
  // ---------------------------------------------------------------
  always_comb begin
    bs_cap = '0;
    if (bs_ir == IR_CHIP_IDENTIFICATION) bs_cap = id_word;
    if (bs_ir == IR_USER) bs_cap = user_word;
    ch_cap = '0;
    unique case (ch_ir)
      IR_CHIP_IDENTIFICATION: ch_cap = id_word;
      IR_USER:   ch_cap = user_word;
      IR_OTPRD:  ch_cap = otp_block ? 32'h0000_0000 : s_q.rdata;
      default:   ch_cap = '0;
    endcase
  end

  // boundary scan tap sits nearest tdi
  tap_fsm #(.DR_W(32)) u_bscan (
    .clk      (clk),
    .rst_b    (rst_b),
    .tck_rise (tck_rise),
    .tck_fall (tck_fall),
    .tms      (s_q.p2.tms),
    .tdi      (s_q.p2.tdi),
    .dr_cap   (bs_cap),
    .dr_one   (bs_ir == IR_BYPASS),
    .ir       (bs_ir),
    .dr_upd   (bs_dr),
    .upd_dr   (),
    .in_tlr   (),
    .tdo      (bs_tdo),
    .tdo_en   (bs_oe)
  );

  // chip tap fed from the boundary tap output
  tap_fsm #(.DR_W(32)) u_chip (
    .clk      (clk),
    .rst_b    (rst_b),
    .tck_rise (tck_rise),
    .tck_fall (tck_fall),
    .tms      (s_q.p2.tms),
    .tdi      (bs_tdo),
    .dr_cap   (ch_cap),
    .dr_one   (ch_ir == IR_BYPASS),
    .ir       (ch_ir),
    .dr_upd   (ch_dr),
    .upd_dr   (ch_upd),
    .in_tlr   (),
    .tdo      (ch_tdo),
    .tdo_en   (ch_oe)
  );

  // chain output silenced by the security disable bit
  assign tdo    = jtag_off ? 1'b0 : ch_tdo;
  assign tdo_en = jtag_off ? 1'b0 : (ch_oe | bs_oe);

  // jtag otp write only when allowed
  assign otp_wr_ok = ch_upd && (ch_ir == IR_OTPWR) && !jtag_off &&
                     !otp_block && !row_locked(s_q.sec,
                     {5'h00, s_q.otp_addr[10:0]});

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.p1      = '{tck: tck, tms: tms, tdi: tdi};
    s_d.p2      = s_q.p1;
    s_d.tck_old = s_q.p2.tck;
    s_d.lock_sy = {s_q.lock_sy[0], pll_lock};
    s_d.rdata   = otp_mem[s_q.rd_ptr];
    s_d.busy    = 1'b0;
    unique case (s_q.boot)
      // hold until the pll is locked again
      B_WAIT: begin
        s_d.rd_ptr = SEC_ROW;                 // row zero read ahead
        if (s_q.lock_sy[1]) begin
          s_d.boot   = B_SEC;
          s_d.rd_ptr = SEC_ROW + 11'h001;     // read lags pointer a cycle
        end
      end
      // security word fetched from row zero
      B_SEC: begin
        s_d.sec    = s_q.rdata;
        s_d.rd_ptr = s_q.rd_ptr + 11'h001;
        s_d.boot   = B_COPY;
      end
      // rows 1 to 1024 copied into sram, one per cycle
      B_COPY: begin
        s_d.rd_ptr = s_q.rd_ptr + 11'h001;
        s_d.cp_ptr = s_q.cp_ptr + 10'h001;
        if (s_q.cp_ptr == {SRAM_ADDR_W{1'b1}}) s_d.boot = B_RUN;
      end
      B_RUN: s_d.rd_ptr = s_q.otp_addr[10:0];
    endcase
    // programming address port
    if (prog_wr) begin
      s_d.otp_addr = prog.addr;
      s_d.busy     = 1'b1;
    end
    if (ch_upd && (ch_ir == IR_OTPRD) && !otp_block)
      s_d.otp_addr = ch_dr[15:0];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{p1: '0, p2: '0, tck_old: 1'b0, lock_sy: 2'b00,
               boot: B_WAIT, sec: SEC_RESET, rd_ptr: '0, rdata: '0,
               cp_ptr: '0, otp_addr: '0, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // storage writes: otp programming and byte-lane sram
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    // control port bit 0 fires the write of the data port word
    if (prog_wr && prog.ctrl[0] && !row_locked(s_q.sec, prog.addr))
      otp_mem[prog.addr[10:0]] <= prog.data;
    else if (otp_wr_ok)
      otp_mem[s_q.otp_addr[10:0]] <= ch_dr;
    if (s_q.boot == B_COPY)
      sram[s_q.cp_ptr] <= s_q.rdata;
    else if (mem_en && mem_we) begin
      for (int b = 0; b < 4; b++) begin
        if (mem_be[b]) sram[mem_addr][8*b +: 8] <= mem_wdata[8*b +: 8];
      end
    end
  end

  // single cycle read port
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) mem_rdata <= '0;
    else if (mem_en && !mem_we) mem_rdata <= sram[mem_addr];
  end

  assign boot_go   = (s_q.boot == B_RUN);
  assign sec_reg   = s_q.sec;
  assign prog_busy = s_q.busy;

endmodule : tap_chain
`default_nettype wire

// ---- inc/tap_pkg.sv ----
// constants, types and the behaviour list for the tile test access block
// ---------------------------------------------------------------------
// Function
// - otp store is four sectors of 512 rows of 32-bit words, 8KB.
// - at power up the security register is fetched from the otp store.
// - further otp words are copied to sram and run before other code.
// - otp programming address is a 16-bit port, resource id 0x100200.
// - otp words to program enter on a 32-bit port, id 0x200100.
// - otp programming control is a 16-bit port, resource id 0x100300.
// - byte, half-word and word memory accesses complete in one cycle.
// - shared sram is 32 bits wide, holding 16 and 32-bit instructions.
// - after reset the chain holds two taps: boundary scan and chip.
// - boundary scan tap behaves as a standard 1149.1 tap.
// - chip tap reaches tile, switch and otp for loading and debug; here its instructions reach only the otp.
// - five test clocks with mode select high reset the jtag logic.
// - chip_identification: version, part number, manufacturer, bit 0 fixed one.
// - usercode top ten bits are security bits 22 to 31, then revision.
// - unprogrammed otp gives an all-zero user id field.
// - global reset asserts asynchronously without a clock edge.
// - boot begins only after reset release and regained pll lock.
// - security bit 0 disables the jtag interface entirely.
// - security bit 13 blocks all jtag reads and writes of the otp.
// ---------------------------------------------------------------------
package tap_pkg;

  // otp organisation
  localparam int OTP_SECTORS   = 4;
  localparam int OTP_ROWS      = 512;
  localparam int OTP_WORD_W    = 32;
  localparam int OTP_ADDR_W    = 11;
  localparam int SRAM_ADDR_W   = 10;

  // otp programming port identities
  localparam logic [23:0] RES_OTP_ADDR = 24'h100200;
  localparam logic [23:0] RES_OTP_DATA = 24'h200100;
  localparam logic [23:0] RES_OTP_CTRL = 24'h100300;

  // security register fields
  localparam int SEC_JTAG_OFF  = 0;
  localparam int SEC_OTP_BLOCK = 13;
  localparam int SEC_UID_LSB   = 22;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  localparam logic [10:0] SEC_ROW   = 11'h000;

  // tap figures
  localparam int IR_W          = 4;
  localparam logic [2:0] TLR_HOLD = 3'h5;
  localparam logic [3:0] IR_BYPASS  = 4'hF;
  localparam logic [3:0] IR_CHIP_IDENTIFICATION  = 4'h1;
  localparam logic [3:0] IR_USER    = 4'h2;
  localparam logic [3:0] IR_OTPRD   = 4'h4;
  localparam logic [3:0] IR_OTPWR   = 4'h5;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // identity fields (values arbitrary)
  localparam logic [3:0]  ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART    = 16'h0ABC;
  localparam logic [10:0] ID_MAKER   = 11'h155;
  localparam logic [15:0] SILICON_REV = 16'h0001;

  // tap controller states, gray along the usual path
  typedef enum logic [3:0] {
    TLR  = 4'h0, RTI  = 4'h1, SDR_S = 4'h3, CDR  = 4'h2,
    SDR  = 4'h6, E1DR = 4'h7, PDR  = 4'h5, E2DR = 4'h4,
    UDR  = 4'hC, SIR_S = 4'hD, CIR = 4'hF, SIR  = 4'hE,
    E1IR = 4'hA, PIR  = 4'hB, E2IR = 4'h9, UIR  = 4'h8
  } tap_state_type;

  // jtag pins after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_pins_type;

  // otp programming request
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
    logic [15:0] ctrl;
  } otp_prog_type;

endpackage : tap_pkg

// ---- src/tap_fsm.sv ----
// one jtag tap: controller, instruction register and shift register
`timescale 1ns/100ps
`default_nettype none
module tap_fsm
  import tap_pkg::*;
#(
  parameter int DR_W = 32
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  // sampled test clock edge and pins
  input  wire logic            tck_rise,
  input  wire logic            tck_fall,
  input  wire logic            tms,
  input  wire logic            tdi,
  // data register capture value and width select
  input  wire logic [DR_W-1:0] dr_cap,
  input  wire logic            dr_one,
  // status
  output logic [IR_W-1:0]      ir,
  output logic [DR_W-1:0]      dr_upd,
  output logic                 upd_dr,
  output logic                 in_tlr,
  output logic                 tdo,
  output logic                 tdo_en
);

  typedef struct packed {
    tap_state_type   st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [DR_W-1:0] dr;
    logic            tdo;
    logic            tdo_en;
    logic            upd;
  } fsm_type;

  fsm_type s_q;
  fsm_type s_d;

  // next tap state per 1149.1 table
  function automatic tap_state_type nxt(input tap_state_type c,
                                        input logic m);
    unique case (c)
      TLR:   nxt = m ? TLR   : RTI;
      RTI:   nxt = m ? SDR_S : RTI;
      SDR_S: nxt = m ? SIR_S : CDR;
      CDR:   nxt = m ? E1DR  : SDR;
      SDR:   nxt = m ? E1DR  : SDR;
      E1DR:  nxt = m ? UDR   : PDR;
      PDR:   nxt = m ? E2DR  : PDR;
      E2DR:  nxt = m ? UDR   : SDR;
      UDR:   nxt = m ? SDR_S : RTI;
      SIR_S: nxt = m ? TLR   : CIR;
      CIR:   nxt = m ? E1IR  : SIR;
      SIR:   nxt = m ? E1IR  : SIR;
      E1IR:  nxt = m ? UIR   : PIR;
      PIR:   nxt = m ? E2IR  : PIR;
      E2IR:  nxt = m ? UIR   : SIR;
      UIR:   nxt = m ? SDR_S : RTI;
    endcase
  endfunction : nxt

  // state step on rising test clock, tdo on falling
  always_comb begin
    s_d     = s_q;
    s_d.upd = 1'b0;
    if (tck_rise) begin
      unique case (s_q.st)
        TLR:  s_d.ir = IR_CHIP_IDENTIFICATION;
        CDR:  s_d.dr = dr_cap;
        SDR:  begin
          if (dr_one) s_d.dr = {{(DR_W-1){1'b0}}, tdi};
          else s_d.dr = {tdi, s_q.dr[DR_W-1:1]};
        end
        CIR:  s_d.ir_sh = IR_CAPTURE;
        SIR:  s_d.ir_sh = {tdi, s_q.ir_sh[IR_W-1:1]};
        UIR:  s_d.ir = s_q.ir_sh;
        UDR:  s_d.upd = 1'b1;
        default: ;
      endcase
      s_d.st = nxt(s_q.st, tms);
    end
    if (tck_fall) begin
      s_d.tdo_en = (s_q.st == SDR) || (s_q.st == SIR);
      s_d.tdo    = (s_q.st == SIR) ? s_q.ir_sh[0] : s_q.dr[0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: TLR, ir_sh: '0, ir: IR_CHIP_IDENTIFICATION, dr: '0,
               tdo: 1'b0, tdo_en: 1'b0, upd: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ir     = s_q.ir;
  assign dr_upd = s_q.dr;
  assign upd_dr = s_q.upd;
  assign in_tlr = (s_q.st == TLR);
  assign tdo    = s_q.tdo;
  assign tdo_en = s_q.tdo_en;

endmodule : tap_fsm
`default_nettype wire

// ---- verif/tap_chain_assertions.sv ----
// assertion checker watching the chain ports
`timescale 1ns/100ps
`default_nettype none
module tap_chain_assertions
  import tap_pkg::*;
#(
  parameter int SECTORS = OTP_SECTORS,
  parameter int ROWS    = OTP_ROWS
) (
  // clock, reset and jtag pins
  input wire logic                   clk, rst_b, tck, tms, tdi, tdo, tdo_en,
  // boot and otp programming
  input wire logic                   pll_lock, boot_go, prog_wr, prog_busy,
  input wire logic [31:0]            sec_reg,
  input wire otp_prog_type           prog,
  // sram port
  input wire logic                   mem_en, mem_we,
  input wire logic [3:0]             mem_be,
  input wire logic [SRAM_ADDR_W-1:0] mem_addr,
  input wire logic [31:0]            mem_wdata, mem_rdata
);
  // --------------------------------------------------------------
  // helper counters
  // --------------------------------------------------------------
  logic        tck_q;
  logic [2:0]  hi_q;
  logic [10:0] lock_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // tck rises seen with mode select high, cycles of lock before boot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_q  <= 1'b0;
      hi_q   <= 3'h0;
      lock_q <= 11'h000;
    end else begin
      tck_q  <= tck;
      if (tck && !tck_q) begin
        hi_q <= !tms ? 3'h0 : (hi_q == 3'h7) ? hi_q : hi_q + 3'h1;
      end
      lock_q <= (pll_lock && !boot_go) ? lock_q + 11'h001 : 11'h000;
    end
  end

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  property p_rst_quiet;
    $rose(rst_b) |-> !boot_go && !tdo_en && sec_reg == 32'h0000_0000;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not idle after reset");
  property p_boot_copy;
    $rose(boot_go) |-> lock_q >= 11'd1024 && lock_q <= 11'd1040;
  endproperty
  a_boot_copy: assert property (p_boot_copy)
    else $error("boot began outside the copy span");
  property p_boot_lock;
    $rose(boot_go) |-> $past(pll_lock, 8);
  endproperty
  a_boot_lock: assert property (p_boot_lock)
    else $error("boot began without lock");
  property p_boot_hold;
    boot_go |=> boot_go;
  endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("boot flag dropped");
  property p_sec_hold;
    $changed(sec_reg) |-> !boot_go;
  endproperty
  a_sec_hold: assert property (p_sec_hold)
    else $error("security word changed after boot");
  property p_jtag_off;
    $past(sec_reg[0], 2) && sec_reg[0] |-> !tdo && !tdo_en;
  endproperty
  a_jtag_off: assert property (p_jtag_off)
    else $error("jtag active while disabled");
  property p_prog_ack;
    prog_wr |=> prog_busy;
  endproperty
  a_prog_ack: assert property (p_prog_ack)
    else $error("program write not acknowledged");
  property p_busy_cause;
    prog_busy |-> $past(prog_wr);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without a program write");
  property p_tlr;
    hi_q == 3'h5 |-> ##[0:8] !tdo_en;
  endproperty
  a_tlr: assert property (p_tlr)
    else $error("still shifting after five mode highs");
  property p_tdo_edge;
    $changed(tdo) |-> !tck;
  endproperty
  a_tdo_edge: assert property (p_tdo_edge)
    else $error("data out moved while test clock high");
endmodule : tap_chain_assertions
`default_nettype wire

// ---- verif/jtag_host.sv ----
// debugger model driving the jtag pins
`timescale 1ns/100ps
`default_nettype none
module jtag_host (
  // pins toward the device
  output logic     tck, tms, tdi,
  // chain data back
  input wire logic tdo
);
  // test clock rests low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one test clock, mode and data set while the clock is low
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    o = tdo;
    #80 tck = 1'b0;
  endtask : step
  // exactly five clocks with mode select high
  task automatic reset_tap;
    logic o;
    #7;
    repeat (5) step(1'b1, 1'b0, o);
    tdi = ~tdi;
  endtask : reset_tap
  // walk to shift, move n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic o;
    #7;
    dout = '0;
    step(1'b0, 1'b0, o);
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    tdi = ~tdi;
  endtask : scan
endmodule : jtag_host
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the two-tap chain
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tap_pkg::*;
  // --------------------------------------------------------------
  // constants, rows and signals
  // --------------------------------------------------------------
  localparam logic [31:0] ID_W   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  localparam logic [31:0] SEC_W  = 32'hFFC0_2000;
  localparam logic [31:0] BOOT_W = 32'hCAFE_F00D;
  typedef struct packed {
    logic [SRAM_ADDR_W-1:0] a;
    logic [3:0]             be;
    logic [31:0]            wd;
    logic [31:0]            ex;
  } mem_row_type;
  localparam mem_row_type MEM_ROWS [4] = '{
    '{10'h005, 4'hF, 32'h1122_3344, 32'h1122_3344},
    '{10'h005, 4'h2, 32'hAABB_CCDD, 32'h1122_CC44},
    '{10'h005, 4'hC, 32'h5566_7788, 32'h5566_CC44},
    '{10'h006, 4'h1, 32'h0000_00EE, 32'h0000_00EE}};
  logic                   clk, rst_b, tck, tms, tdi, tdo, tdo_en;
  logic                   pll_lock, boot_go, prog_wr, prog_busy;
  logic                   mem_en, mem_we;
  logic [31:0]            sec_reg, mem_wdata, mem_rdata;
  logic [3:0]             mem_be;
  logic [SRAM_ADDR_W-1:0] mem_addr;
  otp_prog_type           prog;
  logic [63:0]            got;
  int                     err_total, tests_run;

  tap_chain dut (.clk, .rst_b, .tck, .tms, .tdi, .tdo, .tdo_en, .pll_lock,
    .boot_go, .sec_reg, .prog_wr, .prog, .prog_busy, .mem_en, .mem_we,
    .mem_be, .mem_addr, .mem_wdata, .mem_rdata);
  jtag_host host (.tck, .tms, .tdi, .tdo);

  // system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic check(input string nm, input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task close_out;
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // reset, then lock and wait for the boot flag
  task automatic boot;
    @(posedge clk);
    rst_b    <= 1'b0;
    pll_lock <= 1'b0;
    #1 check("boot_go async", {63'h0, boot_go}, 64'h0);
    repeat (12) @(posedge clk);
    check("reset outs", {sec_reg, 30'h0, tdo, tdo_en}, 64'h0);
    rst_b <= 1'b1;
    repeat (30) @(posedge clk);
    check("boot_go early", {63'h0, boot_go}, 64'h0);
    pll_lock <= 1'b1;
    for (int i = 0; i < 1200 && boot_go !== 1'b1; i++) @(posedge clk);
    #1 check("boot_go", {63'h0, boot_go}, 64'h1);
  endtask : boot
  task automatic prog_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    prog_wr <= 1'b1;
    prog    <= {a, d, 16'h0001};
    @(posedge clk);
    prog_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : prog_write
  // write with byte enables, read back one cycle later
  task automatic mem_rw(input mem_row_type r);
    @(posedge clk);
    mem_en    <= 1'b1;
    mem_we    <= 1'b1;
    mem_be    <= r.be;
    mem_addr  <= r.a;
    mem_wdata <= r.wd;
    @(posedge clk);
    mem_we <= 1'b0;
    @(posedge clk);
    mem_en <= 1'b0;
    #1 check("mem", {32'h0, mem_rdata}, {32'h0, r.ex});
  endtask : mem_rw
  // chip tap otp read, boundary tap in bypass
  task automatic otp_read(input logic [15:0] a, input logic [31:0] ex);
    host.scan(1'b1, 8, 64'hF4, got);
    host.scan(1'b0, 33, {48'h0, a}, got);
    host.scan(1'b0, 33, 64'h0, got);
    check("otp read", {32'h0, got[31:0]}, {32'h0, ex});
  endtask : otp_read
  // --------------------------------------------------------------
  // sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    pll_lock = 1'b0;
    prog_wr = 1'b0;
    prog = '0;
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_be = 4'h0;
    mem_addr = '0;
    mem_wdata = 32'h0;
    err_total = 0;
    tests_run = 0;
    boot();
    check("sec blank", {32'h0, sec_reg}, 64'h0);
    host.reset_tap();
    host.scan(1'b0, 64, 64'h0, got);
    check("id chain", got, {ID_W, ID_W});
    host.scan(1'b1, 8, 64'hF2, got);
    check("ir capture", got, 64'h11);
    host.scan(1'b0, 33, 64'h0, got);
    check("user blank", {32'h0, got[31:0]}, {48'h0, SILICON_REV});
    host.reset_tap();
    host.scan(1'b0, 64, 64'h0, got);
    check("id after tlr", got, {ID_W, ID_W});
    foreach (MEM_ROWS[i]) mem_rw(MEM_ROWS[i]);
    prog_write(16'h0001, BOOT_W);
    prog_write(16'h0000, SEC_W);
    otp_read(16'h0001, BOOT_W);
    // jtag otp write: latch row 2 by a read update, then write it
    host.scan(1'b1, 8, 64'hF4, got);
    host.scan(1'b0, 33, 64'h2, got);
    host.scan(1'b1, 8, 64'hF5, got);
    host.scan(1'b0, 33, 64'h1234_5678, got);
    otp_read(16'h0002, 32'h1234_5678);
    boot();
    check("sec", {32'h0, sec_reg}, {32'h0, SEC_W});
    mem_rw('{10'h000, 4'h0, 32'h0, BOOT_W});
    host.scan(1'b1, 8, 64'hF2, got);
    host.scan(1'b0, 33, 64'h0, got);
    check("user", {32'h0, got[31:0]},
          {32'h0, SEC_W[31:22], 6'h00, SILICON_REV});
    otp_read(16'h0001, 32'h0);
    prog_write(16'h0000, SEC_W | 32'h1);
    boot();
    host.scan(1'b0, 64, 64'h0, got);
    check("jtag off", got, 64'h0);
    close_out();
  end
  initial begin
    #600_000;
    err_total++;
    close_out();
  end
endmodule : testbench

bind tap_chain tap_chain_assertions #(.SECTORS(SECTORS), .ROWS(ROWS)) chk (
  .clk, .rst_b, .tck, .tms, .tdi, .tdo, .tdo_en, .pll_lock, .boot_go,
  .prog_wr, .prog_busy, .sec_reg, .prog, .mem_en, .mem_we, .mem_be,
  .mem_addr, .mem_wdata, .mem_rdata);
`default_nettype wire
